// File: rtl/bst_dev.sv
`timescale 1ns/1ps
`default_nettype none
module bst_dev #(
    parameter int BSR_W = bst_pkg::BSR_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    bst_if.dev link,
    input wire logic [BSR_W-1:0] ring_in,
    input wire logic mem_oe,
    output logic [BSR_W-1:0] ring_out,
    output logic ext_mode,
    output logic out_enable
);
    // Pin synchronisers: change counts when stages two and three agree
    logic [2:0] s_tck, s_tms, s_tdi;
    logic tck_l, tms_l, tdi_l;
    logic [2:0] next_s_tck, next_s_tms, next_s_tdi;
    logic next_tck_l, next_tms_l, next_tdi_l;
    bst_pkg::bst_state_e st, next_st;
    logic [bst_pkg::IR_W-1:0] ir, ir_sh, next_ir, next_ir_sh;
    logic [bst_pkg::ID_W-1:0] id_sh, next_id_sh;
    logic [BSR_W-1:0] bsr, bsr_upd, next_bsr, next_bsr_upd;
    logic byp, next_byp, tdo_q, next_tdo_q, oe_n, next_oe_n;
    logic next_ext, next_oe;
    logic rise, fall, ser;

    // Instructions that put the boundary ring on the serial path
    function automatic logic on_ring(logic [bst_pkg::IR_W-1:0] code);
        on_ring = code == bst_pkg::OP_EXTEST ||
                  code == bst_pkg::OP_SAMPLEZ ||
                  code == bst_pkg::OP_SAMPLE;
    endfunction

    always_comb begin
        next_s_tck = {s_tck[1:0], link.tck};
        next_s_tms = {s_tms[1:0], link.tms};
        next_s_tdi = {s_tdi[1:0], link.tdi};
        next_tck_l = (s_tck[1] == s_tck[2]) ? s_tck[2] : tck_l;
        next_tms_l = (s_tms[1] == s_tms[2]) ? s_tms[2] : tms_l;
        next_tdi_l = (s_tdi[1] == s_tdi[2]) ? s_tdi[2] : tdi_l;
        rise = next_tck_l & ~tck_l;
        fall = ~next_tck_l & tck_l;
        next_st = st;
        next_ir = ir;
        next_ir_sh = ir_sh;
        next_id_sh = id_sh;
        next_bsr = bsr;
        next_bsr_upd = bsr_upd;
        next_byp = byp;
        if (rise) begin
            next_st = bst_pkg::bst_next(st, tms_l);
            case (st)
                bst_pkg::CAP_IR:
                    next_ir_sh = {1'b0, bst_pkg::IR_CAPTURE};
                bst_pkg::SH_IR:
                    next_ir_sh = {tdi_l, ir_sh[bst_pkg::IR_W-1:1]};
                bst_pkg::UPD_IR: next_ir = ir_sh;
                bst_pkg::CAP_DR: begin
                    // Fast-toggling pins may be caught mid-edge
                    if (ir == bst_pkg::OP_IDCODE)
                        next_id_sh = bst_pkg::ID_VALUE;
                    else if (on_ring(ir))
                        next_bsr = ring_in;
                    else
                        next_byp = 1'b0;
                end
                bst_pkg::SH_DR: begin
                    if (ir == bst_pkg::OP_IDCODE)
                        next_id_sh = {tdi_l, id_sh[bst_pkg::ID_W-1:1]};
                    else if (on_ring(ir))
                        next_bsr = {tdi_l, bsr[BSR_W-1:1]};
                    else
                        next_byp = tdi_l;
                end
                bst_pkg::UPD_DR:
                    if (ir == bst_pkg::OP_SAMPLE || ir == bst_pkg::OP_EXTEST)
                        next_bsr_upd = bsr;
                default: ;
            endcase
            // Act on entry, so no stale float survives in reset state
            if (next_st == bst_pkg::TLR) begin
                next_ir = bst_pkg::OP_IDCODE;
                next_bsr_upd[bst_pkg::OE_CELL] = 1'b1;
            end
        end
        if (ir == bst_pkg::OP_IDCODE)
            ser = id_sh[0];
        else if (on_ring(ir))
            ser = bsr[0];
        else
            ser = byp;
        next_tdo_q = tdo_q;
        next_oe_n = oe_n;
        if (fall) begin
            next_tdo_q = (st == bst_pkg::SH_IR) ? ir_sh[0] : ser;
            next_oe_n = !(st == bst_pkg::SH_IR || st == bst_pkg::SH_DR);
        end
        next_ext = (ir == bst_pkg::OP_EXTEST);
        // Memory drive only gated, never redirected
        next_oe = mem_oe && (ir != bst_pkg::OP_SAMPLEZ) &&
                  !(next_ext && !bsr_upd[bst_pkg::OE_CELL]);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_tck <= 3'h0;
            s_tms <= 3'h7;
            s_tdi <= 3'h7;
            tck_l <= 1'b0;
            tms_l <= 1'b1;
            tdi_l <= 1'b1;
            st <= bst_pkg::TLR;
            ir <= bst_pkg::OP_IDCODE;
            ir_sh <= 3'h0;
            id_sh <= 32'h0;
            bsr <= '0;
            bsr_upd <= BSR_W'(1) << bst_pkg::OE_CELL;
            byp <= 1'b0;
            tdo_q <= 1'b0;
            oe_n <= 1'b1;
            ring_out <= BSR_W'(1) << bst_pkg::OE_CELL;
            ext_mode <= 1'b0;
            out_enable <= 1'b0;
        end else begin
            s_tck <= next_s_tck;
            s_tms <= next_s_tms;
            s_tdi <= next_s_tdi;
            tck_l <= next_tck_l;
            tms_l <= next_tms_l;
            tdi_l <= next_tdi_l;
            st <= next_st;
            ir <= next_ir;
            ir_sh <= next_ir_sh;
            id_sh <= next_id_sh;
            bsr <= next_bsr;
            bsr_upd <= next_bsr_upd;
            byp <= next_byp;
            tdo_q <= next_tdo_q;
            oe_n <= next_oe_n;
            ring_out <= next_bsr_upd;
            ext_mode <= next_ext;
            out_enable <= next_oe;
        end
    end
    assign link.tdo_out = tdo_q;
    assign link.tdo_oe_n = oe_n;
endmodule
`default_nettype wire

// File: shared/bst_pkg.sv
// Behaviour
// - Sample on test-clock rise, drive on fall
// - Data enters at MSB, leaves at LSB
// - Data-out drives only while shifting
// - Five rising edges mode-high reset port
// - Instruction selects exactly one serial register
// - Three-bit instruction, identification at reset
// - Instruction capture loads binary 01
// - New instruction applies at instruction update
// - One-bit bypass register, captures zero
// - Boundary register captures ring, then shifts
// - One scan cell per bump, spares included
// - Identification capture loads fixed 32-bit code
// - Controller uses only five defined codes
// - High-impedance sample floats outputs until update
// - Sample/preload captures pin snapshot
// - Preload sets latched parallel cell outputs
// - Capture shifts out while preload shifts in
// - Test clock at most 20 MHz
// - Codes: 000 external, 001 ident, 010 float
// - Identification fields revision, device, vendor, one
// - Cell 47 drives or floats outputs externally
// - Bypass forms path in data shift
package bst_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 107;
    localparam int OE_CELL = 47;
    localparam int RESET_ONES = 5;
    localparam logic [2:0] OP_EXTEST = 3'h0;
    localparam logic [2:0] OP_IDCODE = 3'h1;
    localparam logic [2:0] OP_SAMPLEZ = 3'h2;
    localparam logic [2:0] OP_SAMPLE = 3'h4;
    localparam logic [2:0] OP_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic [2:0] REV_CODE = 3'h5;      // Arbitrary value
    localparam logic [16:0] DEV_CODE = 17'h00abc; // Arbitrary value
    localparam logic [10:0] VEND_CODE = 11'h05a;  // Arbitrary value
    localparam logic [31:0] ID_VALUE = {REV_CODE, DEV_CODE, VEND_CODE, 1'b1};
    localparam real TCK_MAX_MHZ = 20.0;
    localparam real SYS_MHZ = 250.0;
    // Rounded up, so the divided test clock never beats its limit
    localparam int TCK_HALF = $rtoi($ceil(SYS_MHZ / TCK_MAX_MHZ / 2.0));
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
        SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040,
        EX2_DR = 16'h0080, UPD_DR = 16'h0100, SEL_IR = 16'h0200,
        CAP_IR = 16'h0400, SH_IR = 16'h0800, EX1_IR = 16'h1000,
        PA_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
    } bst_state_e;
    function automatic bst_state_e bst_next(bst_state_e s, logic m);
        case (s)
            TLR: bst_next = m ? TLR : RTI;
            RTI: bst_next = m ? SEL_DR : RTI;
            SEL_DR: bst_next = m ? SEL_IR : CAP_DR;
            CAP_DR: bst_next = m ? EX1_DR : SH_DR;
            SH_DR: bst_next = m ? EX1_DR : SH_DR;
            EX1_DR: bst_next = m ? UPD_DR : PA_DR;
            PA_DR: bst_next = m ? EX2_DR : PA_DR;
            EX2_DR: bst_next = m ? UPD_DR : SH_DR;
            UPD_DR: bst_next = m ? SEL_DR : RTI;
            SEL_IR: bst_next = m ? TLR : CAP_IR;
            CAP_IR: bst_next = m ? EX1_IR : SH_IR;
            SH_IR: bst_next = m ? EX1_IR : SH_IR;
            EX1_IR: bst_next = m ? UPD_IR : PA_IR;
            PA_IR: bst_next = m ? EX2_IR : PA_IR;
            EX2_IR: bst_next = m ? UPD_IR : SH_IR;
            UPD_IR: bst_next = m ? SEL_DR : RTI;
            default: bst_next = TLR;
        endcase
    endfunction
endpackage

// File: shared/bst_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bst_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_out;
    logic tdo_oe_n;
    wire tdo_line = tdo_oe_n ? 1'b1 : tdo_out;
    modport dev (input tck, input tms, input tdi, output tdo_out,
                 output tdo_oe_n);
    modport ctl (output tck, output tms, output tdi, input tdo_line);
endinterface
`default_nettype wire

// File: rtl/bst_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module bst_ctl #(
    parameter int HALF = bst_pkg::TCK_HALF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    bst_if.ctl link,
    input wire logic step_req,
    input wire logic step_tms,
    input wire logic step_tdi,
    output logic step_busy,
    output logic step_done,
    output logic step_tdo
);
    // Divider sets test clock no faster than limit
    logic [7:0] cnt, next_cnt;
    logic tck, next_tck, busy, next_busy, done, next_done;
    logic tms, next_tms, tdi, next_tdi, tdo, next_tdo;
    always_comb begin
        next_cnt = cnt;
        next_tck = tck;
        next_busy = busy;
        next_done = 1'b0;
        next_tms = tms;
        next_tdi = tdi;
        next_tdo = tdo;
        if (!busy) begin
            if (step_req) begin
                next_busy = 1'b1;
                next_tms = step_tms;
                next_tdi = step_tdi;
                next_cnt = 8'h0;
            end
        end else if (cnt == 8'(HALF - 1)) begin
            next_cnt = 8'h0;
            next_tck = ~tck;
            if (!tck)
                next_tdo = link.tdo_line;
            else begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end else
            next_cnt = cnt + 8'h1;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h0;
            tck <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            tms <= 1'b1;
            tdi <= 1'b1;
            tdo <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tck <= next_tck;
            busy <= next_busy;
            done <= next_done;
            tms <= next_tms;
            tdi <= next_tdi;
            tdo <= next_tdo;
        end
    end
    assign link.tck = tck;
    assign link.tms = tms;
    assign link.tdi = tdi;
    assign step_busy = busy;
    assign step_done = done;
    assign step_tdo = tdo;
endmodule
`default_nettype wire

// File: verification/bst_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bst_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_out,
    input wire logic tdo_oe_n
);
    logic tck_q;
    logic [2:0] ones;
    logic [2:0] next_ones;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Counts mode-high clock rises; saturates so the flag stays readable
    always_comb begin
        next_ones = ones;
        if (tck && !tck_q) begin
            next_ones = !tms ? 3'h0 : (ones == 3'h5 ? ones : ones + 3'h1);
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_q <= 1'b0;
            ones <= 3'h0;
        end else begin
            tck_q <= tck;
            ones <= next_ones;
        end
    end
    a_tdo_on_fall: assert property ($changed(tdo_out) |-> !tck)
        else $error("data-out moved while test clock high");
    a_oe_on_fall: assert property ($changed(tdo_oe_n) |-> !tck)
        else $error("data-out enable moved while test clock high");
    a_hiz_after_reset: assert property ($rose(rst_n) |-> tdo_oe_n)
        else $error("data-out driven right after reset");
    a_five_ones_idle: assert property (ones == 3'h5 |-> ##[0:8] tdo_oe_n)
        else $error("data-out still driven after five mode-high rises");
    a_tck_high_width: assert property ($rose(tck) |-> tck[*7] ##1 !tck)
        else $error("test clock high phase has wrong length");
    a_tck_low_width: assert property ($fell(tck) |-> !tck[*7])
        else $error("test clock low phase too short");
    a_tms_tdi_hold: assert property (tck |-> $stable(tms) && $stable(tdi))
        else $error("mode or data-in moved while test clock high");
    a_tdo_settles: assert property ($fell(tck) |-> ##8 $stable(tdo_out))
        else $error("data-out not settled eight cycles after fall");
    cover property (!tdo_oe_n);
    cover property (ones == 3'h5);
    cover property ($rose(tck) && !tms);
endmodule
`default_nettype wire

// File: verification/boundary_scan_tap_test.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_test;
    localparam logic [106:0] RING = 107'({4{32'hc3a5_0f96}});
    // Bit 47 of this pattern is 0, so the external test later floats
    localparam logic [106:0] PRE = 107'({4{32'h1234_5678}});
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic step_req = 1'b0;
    logic step_tms = 1'b1;
    logic step_tdi = 1'b1;
    logic mem_oe = 1'b1;
    logic [106:0] ring_in = RING;
    logic [106:0] ring_out;
    logic step_busy, step_done, step_tdo, ext_mode, out_enable;
    int fails = 0;
    int n_compared = 0;
    bst_if link();
    bst_dev u_bst_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .ring_in(ring_in), .mem_oe(mem_oe), .ring_out(ring_out),
        .ext_mode(ext_mode), .out_enable(out_enable));
    bst_ctl u_bst_ctl (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .step_req(step_req), .step_tms(step_tms), .step_tdi(step_tdi),
        .step_busy(step_busy), .step_done(step_done), .step_tdo(step_tdo));
    bst_sva u_bst_sva (.sys_clk(sys_clk), .rst_n(rst_n), .tck(link.tck),
        .tms(link.tms), .tdi(link.tdi), .tdo_out(link.tdo_out),
        .tdo_oe_n(link.tdo_oe_n));
    always #2 sys_clk = ~sys_clk;
    task automatic wrap_up();
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [127:0] exp,
                       input logic [127:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input logic m, input logic d, output logic o);
        int k;
        @(posedge sys_clk);
        step_req <= 1'b1;
        step_tms <= m;
        step_tdi <= d;
        @(posedge sys_clk);
        step_req <= 1'b0;
        @(negedge sys_clk);
        chk("step busy", 128'h1, 128'(step_busy));
        k = 0;
        while (step_done !== 1'b1 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 100) chk("step done", 128'h1, 128'h0);
        o = step_tdo;
    endtask
    // Runs from idle through capture, n shifts and update back to idle
    task automatic scan(input bit ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
    task automatic ir(input logic [2:0] code);
        logic [127:0] r;
        scan(1'b1, 3, {125'h0, code}, r);
    endtask
    task automatic t_reset_id();
        logic [127:0] r;
        logic o;
        chk("idle data-out", 128'h1, 128'(link.tdo_line));
        chk("cell 47 preset", 128'h1, 128'(ring_out[47]));
        step(1'b0, 1'b1, o);
        scan(1'b0, 32, '0, r);
        chk("ident", 128'(bst_pkg::ID_VALUE), r);
    endtask
    task automatic t_bypass();
        logic [127:0] r;
        scan(1'b1, 3, {125'h0, bst_pkg::OP_BYPASS}, r);
        chk("ir capture", 128'h1, {126'h0, r[1:0]});
        scan(1'b0, 8, 128'hb6, r);
        chk("bypass path", 128'h6c, r);
    endtask
    task automatic t_sample();
        logic [127:0] r;
        ir(bst_pkg::OP_SAMPLE);
        scan(1'b0, 107, 128'(PRE), r);
        chk("sample capture", 128'(RING), r);
        chk("preload cells", 128'(PRE), 128'(ring_out));
    endtask
    task automatic t_samplez();
        logic [127:0] r;
        ir(bst_pkg::OP_SAMPLEZ);
        chk("float enable", 128'h0, 128'(out_enable));
        scan(1'b0, 107, 128'(PRE), r);
        chk("float path", 128'(RING), r);
        ir(bst_pkg::OP_IDCODE);
        chk("restored enable", 128'h1, 128'(out_enable));
        @(posedge sys_clk);
        mem_oe <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("memory float", 128'h0, 128'(out_enable));
        @(posedge sys_clk);
        mem_oe <= 1'b1;
    endtask
    task automatic t_extest();
        ir(bst_pkg::OP_EXTEST);
        chk("external mode", 128'h1, 128'(ext_mode));
        chk("cell 47 float", 128'h0, 128'(out_enable));
    endtask
    task automatic t_tap_reset();
        logic [127:0] r;
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        chk("mode after reset", 128'h0, 128'(ext_mode));
        chk("cell 47 reset", 128'h1, 128'(ring_out[47]));
        chk("enable after reset", 128'h1, 128'(out_enable));
        chk("data-out after reset", 128'h1, 128'(link.tdo_line));
        step(1'b0, 1'b1, o);
        scan(1'b0, 32, '0, r);
        chk("ident after reset", 128'(bst_pkg::ID_VALUE), r);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_id();
        t_bypass();
        t_sample();
        t_samplez();
        t_extest();
        t_tap_reset();
        wrap_up();
    end
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
